// ===== core/ssc_scanner.v
// scanner working-state machine, scan packet stream and register slave
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defines.vh"
module ssc_scanner #(
  parameter TIMEOUT_CYC = `SSC_REQ_TIMEOUT_MS * (`SSC_CLK_HZ / 1000)
) (
  input  wire        clk,
  input  wire        reset,
  // byte link from the uart receiver and to the transmitter
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  output reg         txValid,
  output reg  [7:0]  txData,
  input  wire        txReady,
  // measurement subsystem
  input  wire        sampleValid,
  input  wire [5:0]  sampleQuality,
  input  wire [14:0] heading_fixed_point,
  input  wire [15:0] range_fixed_point,
  input  wire        sampleNewRev,
  input  wire        motorStablePin,
  input  wire        hwFaultPin,
  output reg         laserEn,
  output reg         measEn,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SCAN = 4'b0010;
  localparam [3:0] ST_REQ  = 4'b0100;
  localparam [3:0] ST_PROT = 4'b1000;
  localparam       BUF_N   = 11;
  // full-width copies so the byte and count fields can be sliced
  localparam [29:0] LEN_SCAN  = `SSC_LEN_SCAN;
  localparam [29:0] LEN_QUERY = `SSC_LEN_QUERY;

  // working state and the request being served
  reg  [3:0]  state_r;
  reg  [3:0]  prev_r;
  reg  [3:0]  target_r;
  reg  [7:0]  reqCmd_r;
  reg         reqLoaded_r;
  reg         forceMode_r;
  reg         softRst_r;
  reg         cmdAck_r;
  // transmit buffer: descriptor plus up to four data bytes
  reg  [7:0]  txBuf_r [0:BUF_N-1];
  reg  [3:0]  txCnt_r;
  reg  [3:0]  txIdx_r;
  reg  [1:0]  stableSync_r;
  reg  [1:0]  faultSync_r;
  reg  [31:0] ctrl_r;
  reg  [31:0] qdata_r;
  reg  [31:0] pktCnt_r;
  // internal nets
  wire        coreRst;
  wire        cmdValid;
  wire [7:0]  cmdCode;
  wire        txBusy;
  wire        txHold;
  wire        fault;
  wire        isScanCmd;
  wire        isQuery;
  wire [7:0]  qType;
  wire        sendSample;
  wire        axiWr;
  integer     i;

  // core reset command reboots the state machine and parser, not the axi slave or pin synchronisers
  assign coreRst = reset | softRst_r;
  assign txBusy  = txValid | (txIdx_r != txCnt_r);
  assign txHold  = txValid & ~txReady;
  assign fault   = faultSync_r[1] | ctrl_r[`SSC_CTRL_FAULT_BIT];
  assign isScanCmd = (reqCmd_r == `SSC_CMD_SCAN) ||
                     (reqCmd_r == `SSC_CMD_FAST_SCAN) ||
                     (reqCmd_r == `SSC_CMD_FORCE_SCAN);
  assign isQuery = (reqCmd_r == `SSC_CMD_IDENT_QRY) ||
                   (reqCmd_r == `SSC_CMD_COND_QRY) ||
                   (reqCmd_r == `SSC_CMD_SAMPLE_PERIOD_QUERY);
  assign qType = (reqCmd_r == `SSC_CMD_IDENT_QRY) ? `SSC_DTYPE_IDENT :
                 (reqCmd_r == `SSC_CMD_COND_QRY)  ? `SSC_DTYPE_COND :
                 `SSC_DTYPE_PERIOD;
  // no sample buffer: a sample arriving while busy is lost
  assign sendSample = state_r[1] && sampleValid && !txBusy && !cmdValid &&
                      (stableSync_r[1] || forceMode_r);

  ssc_req_parser #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_parser (
    .clk      (clk),
    .reset    (coreRst),
    .rxValid  (rxValid),
    .rxData   (rxData),
    .cmdAck   (cmdAck_r),
    .cmdValid (cmdValid),
    .cmdCode  (cmdCode)
  );

  // pin synchronisers
  // only the second stage is read by any other logic
  always @(posedge clk) begin
    if (reset) begin
      stableSync_r <= 2'b00;
      faultSync_r  <= 2'b00;
    end else begin
      stableSync_r <= {stableSync_r[0], motorStablePin};
      faultSync_r  <= {faultSync_r[0], hwFaultPin};
    end
  end

  // working-state machine and transmit loader
  always @(posedge clk) begin
    if (coreRst) begin
      state_r     <= ST_IDLE;
      prev_r      <= ST_IDLE;
      target_r    <= ST_IDLE;
      reqCmd_r    <= 8'h00;
      reqLoaded_r <= 1'b0;
      forceMode_r <= 1'b0;
      softRst_r   <= 1'b0;
      cmdAck_r    <= 1'b0;
      laserEn     <= 1'b0;
      measEn      <= 1'b0;
      txCnt_r     <= 4'h0;
      txIdx_r     <= 4'h0;
      txValid     <= 1'b0;
      txData      <= 8'h00;
      pktCnt_r    <= 32'h00000000;
      for (i = 0; i < BUF_N; i = i + 1)
        txBuf_r[i] <= 8'h00;
    end else begin
      cmdAck_r <= 1'b0;
      // byte sender; a byte on offer always finishes its handshake
      if (txHold) begin
        txValid <= 1'b1;
      end else if (txIdx_r != txCnt_r) begin
        txValid <= 1'b1;
        txData  <= txBuf_r[txIdx_r];
        txIdx_r <= txIdx_r + 4'h1;
      end else begin
        txValid <= 1'b0;
      end
      case (state_r)
        ST_IDLE, ST_PROT: begin
          // a fault while idle is acted on when a request arrives
          laserEn <= 1'b0;
          measEn  <= 1'b0;
          if (cmdValid && !cmdAck_r) begin
            prev_r      <= state_r;
            reqCmd_r    <= cmdCode;
            cmdAck_r    <= 1'b1;
            reqLoaded_r <= 1'b0;
            state_r     <= ST_REQ;
          end
        end
        ST_SCAN: begin
          laserEn <= 1'b1;
          measEn  <= 1'b1;
          if (fault) begin
            // abort the stream; only the byte on offer completes.
            // the index is frozen too, or the sender would run on
            // past the count and wrap through the whole buffer
            txCnt_r <= txIdx_r;
            txIdx_r <= txIdx_r;
            if (!txHold)
              txValid <= 1'b0;
            laserEn <= 1'b0;
            measEn  <= 1'b0;
            state_r <= ST_PROT;
          end else if (cmdValid && !cmdAck_r && !txBusy) begin
            // the held request runs once the packet in flight ends
            prev_r      <= ST_SCAN;
            reqCmd_r    <= cmdCode;
            cmdAck_r    <= 1'b1;
            reqLoaded_r <= 1'b0;
            laserEn     <= 1'b0;
            measEn      <= 1'b0;
            state_r     <= ST_REQ;
          end else if (sendSample) begin
            // one five-byte packet per sample
            txBuf_r[0] <= {sampleQuality, ~sampleNewRev,
                           sampleNewRev};
            txBuf_r[1] <= {heading_fixed_point[6:0], 1'b1};
            txBuf_r[2] <= heading_fixed_point[14:7];
            txBuf_r[3] <= range_fixed_point[7:0];
            txBuf_r[4] <= range_fixed_point[15:8];
            txCnt_r    <= LEN_SCAN[3:0];
            txIdx_r    <= 4'h0;
            // the counter wraps silently once it is full
            pktCnt_r   <= pktCnt_r + 32'h00000001;
          end
        end
        ST_REQ: begin
          // nothing is scanned or sent but the request's own answer
          laserEn <= 1'b0;
          measEn  <= 1'b0;
          if (fault && prev_r != ST_PROT) begin
            // same cut as in scanning: answer bytes not yet out are lost
            txCnt_r <= txIdx_r;
            txIdx_r <= txIdx_r;
            if (!txHold)
              txValid <= 1'b0;
            state_r <= ST_PROT;
          end else if (!reqLoaded_r && !txBusy) begin
            reqLoaded_r <= 1'b1;
            target_r    <= prev_r;
            if (reqCmd_r == `SSC_CMD_CORE_RESET) begin
              // one-cycle pulse: the reset branch clears it again
              softRst_r <= 1'b1;
            end else if (reqCmd_r == `SSC_CMD_STOP) begin
              // stop only matters when scanning
              target_r <= (prev_r == ST_SCAN) ? ST_IDLE
                                              : prev_r;
            end else if (isScanCmd && prev_r != ST_PROT) begin
              forceMode_r <= (reqCmd_r == `SSC_CMD_FORCE_SCAN);
              target_r    <= ST_SCAN;
              txBuf_r[0]  <= `SSC_SYNC_REQ;
              txBuf_r[1]  <= `SSC_SYNC_RSP2;
              txBuf_r[2]  <= LEN_SCAN[7:0];
              txBuf_r[3]  <= LEN_SCAN[15:8];
              txBuf_r[4]  <= LEN_SCAN[23:16];
              txBuf_r[5]  <= {`SSC_MODE_MULTI, LEN_SCAN[29:24]};
              txBuf_r[6]  <= `SSC_DTYPE_SCAN;
              txCnt_r     <= `SSC_DESC_BYTES;
              txIdx_r     <= 4'h0;
            end else if (isQuery) begin
              // a query from scanning ends in idle
              target_r   <= (prev_r == ST_PROT) ? ST_PROT
                                                : ST_IDLE;
              txBuf_r[0] <= `SSC_SYNC_REQ;
              txBuf_r[1] <= `SSC_SYNC_RSP2;
              txBuf_r[2] <= LEN_QUERY[7:0];
              txBuf_r[3] <= LEN_QUERY[15:8];
              txBuf_r[4] <= LEN_QUERY[23:16];
              txBuf_r[5] <= {`SSC_MODE_SINGLE, LEN_QUERY[29:24]};
              txBuf_r[6] <= qType;
              txBuf_r[7] <= qdata_r[7:0];
              txBuf_r[8] <= qdata_r[15:8];
              txBuf_r[9] <= qdata_r[23:16];
              txBuf_r[10] <= qdata_r[31:24];
              txCnt_r    <= `SSC_QRY_BYTES;
              txIdx_r    <= 4'h0;
            end else if (prev_r == ST_SCAN) begin
              // unknown command from scanning: scanning was left
              target_r <= ST_IDLE;
            end
          end else if (reqLoaded_r && !txBusy) begin
            state_r <= target_r;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // axi write: address and data taken together, one outstanding
  // read-only registers ignore writes; unmapped ones answer slverr
  assign axiWr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready;
  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSC_RESP_OKAY;
      ctrl_r        <= `SSC_CTRL_RESET;
      qdata_r       <= `SSC_QDATA_RESET;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
          !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (axiWr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SSC_RESP_OKAY;
        if (s_axi_awaddr == `SSC_REG_CTRL) begin
          if (s_axi_wstrb[0])
            ctrl_r[7:0] <= s_axi_wdata[7:0];
        end else if (s_axi_awaddr == `SSC_REG_QDATA) begin
          for (i = 0; i < 4; i = i + 1)
            if (s_axi_wstrb[i])
              qdata_r[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
        end else if (s_axi_awaddr != `SSC_REG_STATUS &&
                     s_axi_awaddr != `SSC_REG_PKTCNT) begin
          s_axi_bresp <= `SSC_RESP_SLVERR;
        end
      end
    end
  end

  // axi read: data one cycle after the address is taken
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SSC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SSC_RESP_OKAY;
        if (s_axi_araddr == `SSC_REG_CTRL) begin
          s_axi_rdata <= ctrl_r;
        end else if (s_axi_araddr == `SSC_REG_STATUS) begin
          // one-hot state, enables, mode and both synced pins
          s_axi_rdata <= {22'h000000, faultSync_r[1], stableSync_r[1],
                          forceMode_r, measEn, laserEn, 1'b0, state_r};
        end else if (s_axi_araddr == `SSC_REG_QDATA) begin
          s_axi_rdata <= qdata_r;
        end else if (s_axi_araddr == `SSC_REG_PKTCNT) begin
          s_axi_rdata <= pktCnt_r;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SSC_RESP_SLVERR;
        end
      end
    end
  end
endmodule // ssc_scanner
`default_nettype wire

// ===== pkg/ssc_defines.vh
// constants for the scanner state and scan stream block
// Behaviour
// - four states; idle after power-up or reset
// - idle disables laser and measurement; scanning enables
// - request processing: no scan, answer after operation
// - after processing, go where request says
// - hardware fault aborts, enters protection stop
// - protection stop answers queries, refuses scans
// - scanning waits for stable motor before output
// - 0x25 stop to idle; 0x40 core reset
// - 0x20 scan, 0x82 fast scan, 0x21 unconditional
// - 0x50, 0x52, 0x59 are single-response queries
// - stop leaves scanning; ignored in idle, protection
// - core reset returns to idle, clears protection
// - scan restarts a fresh round if scanning
// - scan ignored silently in protection stop
// - descriptor at once, packets after motor stable
// - new request or fault ends scanning
// - one data packet per measurement sample; a sample arriving while a packet is being sent is dropped
// - packet holds flag, inverted flag, check bit one
// - packet holds quality, heading, quarter-mm range
// - request: 0xA5, command, size, payload, xor sum
// - descriptor: A5 5A, 30-bit length, mode, type
// - scan send mode 1, query send mode 0
// - request during stream buffered, handled afterwards
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

`define SSC_SYNC_REQ        8'hA5
`define SSC_SYNC_RSP2       8'h5A
`define SSC_CMD_STOP        8'h25
`define SSC_CMD_CORE_RESET  8'h40
`define SSC_CMD_SCAN        8'h20
`define SSC_CMD_FAST_SCAN   8'h82
`define SSC_CMD_FORCE_SCAN  8'h21
`define SSC_CMD_IDENT_QRY   8'h50
`define SSC_CMD_COND_QRY    8'h52
`define SSC_CMD_SAMPLE_PERIOD_QUERY 8'h59
// bit 7 of the command marks a request with payload
`define SSC_CMD_PAYLOAD_BIT 7

`define SSC_MODE_SINGLE     2'h0
`define SSC_MODE_MULTI      2'h1
// data type codes, arbitrary values
`define SSC_DTYPE_SCAN      8'h01
`define SSC_DTYPE_IDENT     8'h02
`define SSC_DTYPE_COND      8'h03
`define SSC_DTYPE_PERIOD    8'h04
`define SSC_LEN_SCAN        30'h0000005
`define SSC_LEN_QUERY       30'h0000004
`define SSC_DESC_BYTES      4'h7
`define SSC_QRY_BYTES       4'hB

// register byte offsets
`define SSC_REG_CTRL        4'h0
`define SSC_REG_STATUS      4'h4
`define SSC_REG_QDATA       4'h8
`define SSC_REG_PKTCNT      4'hC
`define SSC_CTRL_FAULT_BIT  0
`define SSC_CTRL_RESET      32'h00000000
`define SSC_QDATA_RESET     32'h00000000
`define SSC_RESP_OKAY       2'h0
`define SSC_RESP_SLVERR     2'h2

// timing
`define SSC_CLK_HZ          10000000
`define SSC_REQ_TIMEOUT_MS  5000

`endif

// ===== core/ssc_req_parser.v
// request framer: start byte, command, optional payload and checksum
`timescale 1ns/1ns
`default_nettype none
`include "ssc_defines.vh"
module ssc_req_parser #(
  parameter TIMEOUT_CYC = `SSC_REQ_TIMEOUT_MS * (`SSC_CLK_HZ / 1000)
) (
  input  wire       clk,
  input  wire       reset,
  input  wire       rxValid,
  input  wire [7:0] rxData,
  input  wire       cmdAck,
  output reg        cmdValid,
  output reg  [7:0] cmdCode
);
  localparam [4:0] P_SYNC = 5'b00001;
  localparam [4:0] P_CMD  = 5'b00010;
  localparam [4:0] P_SIZE = 5'b00100;
  localparam [4:0] P_PAY  = 5'b01000;
  localparam [4:0] P_SUM  = 5'b10000;

  reg [4:0]  pState_r;
  reg [7:0]  sum_r;
  reg [7:0]  left_r;
  reg [31:0] tmo_r;

  // framing; a held command is the one-deep request buffer
  always @(posedge clk) begin
    if (reset) begin
      pState_r <= P_SYNC;
      sum_r    <= 8'h00;
      left_r   <= 8'h00;
      tmo_r    <= 32'h00000000;
      cmdValid <= 1'b0;
      cmdCode  <= 8'h00;
    end else begin
      if (cmdAck)
        cmdValid <= 1'b0;
      // a half-sent request is dropped after the timeout
      if (pState_r != P_SYNC && tmo_r >= TIMEOUT_CYC - 1) begin
        pState_r <= P_SYNC;
        tmo_r    <= 32'h00000000;
      end else if (pState_r != P_SYNC) begin
        tmo_r <= tmo_r + 32'h00000001;
      end
      if (rxValid && !(pState_r != P_SYNC && tmo_r >= TIMEOUT_CYC - 1)) begin
        sum_r <= sum_r ^ rxData;
        case (pState_r)
          P_SYNC: begin
            if (rxData == `SSC_SYNC_REQ) begin
              pState_r <= P_CMD;
              sum_r    <= rxData;
              tmo_r    <= 32'h00000000;
            end
          end
          P_CMD: begin
            cmdCode <= rxData;
            if (rxData[`SSC_CMD_PAYLOAD_BIT]) begin
              pState_r <= P_SIZE;
            end else begin
              pState_r <= P_SYNC;
              cmdValid <= 1'b1;
            end
          end
          P_SIZE: begin
            left_r   <= rxData;
            pState_r <= (rxData == 8'h00) ? P_SUM : P_PAY;
          end
          P_PAY: begin
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01)
              pState_r <= P_SUM;
          end
          P_SUM: begin
            pState_r <= P_SYNC;
            // bad checksum drops the request silently
            if (sum_r == rxData)
              cmdValid <= 1'b1;
          end
          default: pState_r <= P_SYNC;
        endcase
      end
    end
  end
endmodule // ssc_req_parser
`default_nettype wire

// ===== verification/ssc_scanner_checker.sv
// port assertions for the scanner state and scan stream block
`timescale 1ns/1ns
`default_nettype none
module ssc_scanner_checker #(
  parameter TIMEOUT_CYC = 200
) (
  input wire       clk,
  input wire       reset,
  input wire       rxValid,
  input wire [7:0] rxData,
  input wire       txValid,
  input wire [7:0] txData,
  input wire       txReady,
  input wire       hwFaultPin,
  input wire       laserEn,
  input wire       measEn,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // reset itself must leave the block quiet, so no disable here
  reset_idle_a: assert property (disable iff (1'b0)
    reset |=> !laserEn && !txValid && !s_axi_bvalid)
    else $error("block not idle after reset");
  enables_pair_a: assert property (laserEn == measEn)
    else $error("laser and measurement enables differ");
  tx_hold_a: assert property (txValid && !txReady |=>
    txValid && $stable(txData))
    else $error("tx byte not held until ready");
  // a query from idle is answered by a descriptor within a few cycles
  query_answer_a: assert property (rxValid && $past(rxValid) &&
    $past(rxData) == 8'hA5 && !laserEn && !txValid &&
    (rxData == 8'h50 || rxData == 8'h52 || rxData == 8'h59)
    |-> ##[1:12] (txValid && txData == 8'hA5))
    else $error("query not answered");
  desc_second_a: assert property (txValid && txReady &&
    txData == 8'hA5 && !laserEn |-> ##[1:4] (txValid && txData == 8'h5A))
    else $error("second descriptor sync byte missing");
  // fault pin passes a two-stage synchroniser first
  fault_stop_a: assert property (hwFaultPin [*4] |-> ##[0:12] !laserEn)
    else $error("fault did not stop scanning");
  stop_idle_a: assert property (rxValid && rxData == 8'h25 &&
    $past(rxValid) && $past(rxData) == 8'hA5 |-> ##[1:40] !laserEn)
    else $error("stop did not disable laser");
  axi_bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid)
    else $error("write response dropped early");
endmodule  // ssc_scanner_checker
bind ssc_scanner ssc_scanner_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk(clk), .reset(reset), .rxValid(rxValid), .rxData(rxData),
  .txValid(txValid), .txData(txData), .txReady(txReady),
  .hwFaultPin(hwFaultPin), .laserEn(laserEn), .measEn(measEn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// ===== verification/ssc_host_model.sv
// host model: request sender and response byte sink
`timescale 1ns/1ns
`default_nettype none
module ssc_host_model (
  input  wire        clk,
  output logic       rxValid,
  output logic [7:0] rxData,
  input  wire        txValid,
  input  wire  [7:0] txData,
  output logic       txReady
);
  logic       slow = 1'b1;
  logic [7:0] got[$];
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
  end
  // slow sink toggles ready so every byte must be held
  always @(posedge clk) begin
    if (txValid && txReady) got.push_back(txData);
    txReady <= slow ? ~txReady : 1'b1;
  end
  // start byte then command; the data line inverts once released
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    rxValid <= 1'b1;
    rxData <= 8'hA5;
    @(posedge clk);
    rxData <= c;
    @(posedge clk);
    rxValid <= 1'b0;
    rxData <= ~c;
    // no answer comes for these, so only a wait tells they are done
    if (c == 8'h25) repeat (10000) @(posedge clk);
    if (c == 8'h40) repeat (20000) @(posedge clk);
  endtask
endmodule  // ssc_host_model
`default_nettype wire

// ===== verification/tb_ssc_scanner.sv
// self-checking bench for the scanner block
`timescale 1ns/1ns
`default_nettype none
module tb_ssc_scanner;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        rxValid, txValid, txReady, laserEn, measEn;
  logic [7:0]  rxData, txData;
  logic        smpV = 1'b0, newRev = 1'b1, motor = 1'b0, fault = 1'b0;
  logic [5:0]  quality = 6'h2A;
  logic [14:0] heading = 15'h1234;
  logic [15:0] rangeV = 16'hBEEF;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, qd = 32'h44332211;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [7:0]  ex[$];
  int          fail_count = 0, checks_done = 0;

  initial forever #50 clk = ~clk;

  ssc_scanner #(.TIMEOUT_CYC(200)) i_dut (.clk(clk), .reset(reset),
    .rxValid(rxValid), .rxData(rxData), .txValid(txValid),
    .txData(txData), .txReady(txReady), .sampleValid(smpV),
    .sampleQuality(quality), .heading_fixed_point(heading),
    .range_fixed_point(rangeV), .sampleNewRev(newRev),
    .motorStablePin(motor), .hwFaultPin(fault), .laserEn(laserEn),
    .measEn(measEn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  ssc_host_model h (.clk(clk), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady));

  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // a bound that runs out ends the run as a failure
  task automatic tmo(input int i);
    if (i >= 200) begin
      fail_count++;
      end_sim();
    end
  endtask
  // axi4-lite write: address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      // ready only after the answer shows, so the slave must hold it
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    tmo(i);
    cmp(bresp, 2'h0);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFFFFFF);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    tmo(i);
    cmp(rresp, 2'h0);
    cmp(rdata & m, e);
  endtask
  // extra quiet time makes any surplus byte show in the count
  task automatic drain();
    int i;
    for (i = 0; i < 200 && h.got.size() < ex.size(); i++) @(posedge clk);
    tmo(i);
    repeat (30) @(posedge clk);
    cmp(h.got.size(), ex.size());
    foreach (ex[k]) if (k < h.got.size()) cmp(h.got[k], ex[k]);
    ex.delete();
    h.got.delete();
  endtask
  task automatic desc(input logic [7:0] len, input logic [1:0] m,
                      input logic [7:0] t);
    ex.push_back(8'hA5);
    ex.push_back(8'h5A);
    ex.push_back(len);
    ex.push_back(8'h00);
    ex.push_back(8'h00);
    ex.push_back({m, 6'h00});
    ex.push_back(t);
  endtask
  task automatic qry(input logic [7:0] c, input logic [7:0] t);
    h.send(c);
    desc(8'h04, 2'h0, t);
    for (int k = 0; k < 4; k++) ex.push_back(qd[8*k +: 8]);
    drain();
  endtask
  task automatic scan(input logic [7:0] c);
    h.send(c);
    desc(8'h05, 2'h1, 8'h01);
    drain();
  endtask
  // one sample pulse and its expected five-byte packet
  task automatic samp();
    @(posedge clk);
    smpV <= 1'b1;
    @(posedge clk);
    smpV <= 1'b0;
    ex.push_back({quality, ~newRev, newRev});
    ex.push_back({heading[6:0], 1'b1});
    ex.push_back(heading[14:7]);
    ex.push_back(rangeV[7:0]);
    ex.push_back(rangeV[15:8]);
    // fresh field values for the next sample
    quality <= quality + 6'h05;
    heading <= heading + 15'h0A3B;
    rangeV <= rangeV - 16'h1111;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdc(4'h4, 32'h1);
    rdc(4'h0, 32'h0);
    wr(4'h8, qd);
    rdc(4'h8, qd);
    // byte lanes: only lanes 1 and 2 of the query data change
    wstrb <= 4'h6;
    wr(4'h8, 32'h0);
    rdc(4'h8, 32'h44000011);
    wstrb <= 4'hF;
    wr(4'h8, qd);
    qry(8'h50, 8'h02);
    qry(8'h52, 8'h03);
    qry(8'h59, 8'h04);
    scan(8'h20);
    cmp(laserEn, 1'b1);
    cmp(measEn, 1'b1);
    samp();
    ex.delete();
    drain();
    motor <= 1'b1;
    repeat (4) @(posedge clk);
    for (int n = 0; n < 2; n++) begin
      samp();
      drain();
      newRev <= 1'b0;
    end
    scan(8'h20);
    qry(8'h52, 8'h03);
    cmp(laserEn, 1'b0);
    motor <= 1'b0;
    h.slow <= 1'b0;
    scan(8'h21);
    samp();
    drain();
    rdc(4'hC, 32'h3);
    h.send(8'h25);
    cmp(laserEn, 1'b0);
    drain();
    h.slow <= 1'b1;
    scan(8'h20);
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    rdc(4'h4, 32'h208);
    fault <= 1'b0;
    h.send(8'h20);
    drain();
    qry(8'h50, 8'h02);
    rdc(4'h4, 32'h8);
    h.send(8'h40);
    rdc(4'h4, 32'h1);
    rdc(4'hC, 32'h0);
    // injected fault is acted on once a request leaves idle
    wr(4'h0, 32'h1);
    h.send(8'h20);
    drain();
    rdc(4'h4, 32'h8, 32'hF);
    wr(4'h0, 32'h0);
    h.send(8'h40);
    scan(8'h20);
    end_sim();
  end
endmodule  // tb_ssc_scanner
`default_nettype wire
